// ==== dv/pcg_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcg_top_tb;
	import pcg_pkg::*;
	logic core_clk;
	logic rst_n;
	logic wb_cyc;
	logic wb_stb;
	logic wb_we;
	logic [PCG_ADDR_W-1:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic sleep_mode;
	logic deep_sleep_mode;
	logic per_access_valid;
	logic [2:0] per_access_unit;
	logic per_access_grant;
	logic per_access_fault;
	logic [7:0] unit_clk;
	logic [7:0] unit_clk_en;
	pcg_mode_t active_mode;
	logic irq;
	logic [15:0] edge_cnt [8];
	logic [31:0] rd;
	int error_cnt;
	int n_tests;
	int bpos [7] = '{16, 17, 18, 12, 4, 0, 1};

	pcg_top DUT (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
		.sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode), .per_access_valid(per_access_valid),
		.per_access_unit(per_access_unit), .per_access_grant(per_access_grant),
		.per_access_fault(per_access_fault), .unit_clk(unit_clk), .unit_clk_en(unit_clk_en),
		.active_mode(active_mode), .irq(irq));
	pcg_unit_model u_units (.rst_n(rst_n), .unit_clk(unit_clk), .edge_cnt(edge_cnt));

	// ***************************************************
	// helpers
	// ***************************************************
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wb_xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat_w <= wd;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		rd = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		if (n >= 20) begin
			error_cnt++;
			$display("unexpected at %0t: no bus answer", $time);
			close_out();
		end
	endtask
	task automatic rchk(input logic [11:0] adr, input logic [31:0] exp);
		wb_xfer(1'b0, adr, 32'h0000_0000);
		check(rd, exp);
	endtask
	task automatic access(input logic [2:0] u, input logic g);
		@(posedge core_clk);
		per_access_valid <= 1'b1;
		per_access_unit <= u;
		@(posedge core_clk);
		per_access_valid <= 1'b0;
		#1;
		check({30'h0, per_access_grant, per_access_fault}, {30'h0, g, !g});
	endtask
	task automatic edges(input int u, input logic [15:0] n);
		logic [15:0] s;
		s = edge_cnt[u];
		tick(10);
		check({16'h0, edge_cnt[u] - s}, {16'h0, n});
	endtask
	function automatic logic [31:0] en_of(input logic [31:0] a, input logic [31:0] b);
		return {24'h0, b[1], b[0], b[4], b[12], b[18], b[17], b[16], a[3]};
	endfunction

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		error_cnt++;
		$display("unexpected at %0t: run timed out", $time);
		close_out();
	end

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		rst_n = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 12'h000;
		wb_sel = 4'hf;
		wb_dat_w = 32'h0;
		sleep_mode = 1'b0;
		deep_sleep_mode = 1'b0;
		per_access_valid = 1'b0;
		per_access_unit = 3'h0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rchk(12'h100 + 12'(i / 2 * 16 + i % 2 * 4), 32'h0);
		end
		check(32'(unit_clk_en), 32'h0);
		access(3'h5, 1'b0);
		// unused positions must not stick
		wb_xfer(1'b1, PCG_OFS_RUN_A, 32'hffff_ffff);
		wb_xfer(1'b1, PCG_OFS_RUN_B, 32'hffff_ffff);
		rchk(PCG_OFS_RUN_A, 32'h0000_0008);
		rchk(PCG_OFS_RUN_B, 32'h0007_1013);
		tick(2);
		check(32'(unit_clk_en), 32'h0000_00ff);
		for (int i = 0; i < 7; i++) begin
			wb_xfer(1'b1, PCG_OFS_RUN_B, 32'h1 << bpos[i]);
			tick(2);
			check(32'(unit_clk_en), en_of(32'h8, 32'h1 << bpos[i]));
			// other unit drawn from 1..7 only; unit 0 still has its gate set here
			access(3'(i + 1), 1'b1);
			access(3'((i + 1) % 7 + 1), 1'b0);
			edges(i + 1, 16'd10);
			edges((i + 1) % 7 + 1, 16'd0);
		end
		wb_xfer(1'b0, PCG_OFS_RUN_A, 32'h0);
		wb_xfer(1'b1, PCG_OFS_RUN_A, rd & ~32'h8);
		wb_xfer(1'b1, PCG_OFS_RUN_B, 32'h0000_0010);
		tick(2);
		access(3'h0, 1'b0);
		edges(0, 16'd0);
		wb_xfer(1'b1, PCG_OFS_SLEEP_A, 32'hffff_ffff);
		wb_xfer(1'b1, PCG_OFS_DEEP_A, 32'hffff_ffff);
		rchk(PCG_OFS_SLEEP_A, 32'h0000_0008);
		rchk(PCG_OFS_DEEP_A, 32'h0000_0008);
		wb_xfer(1'b1, PCG_OFS_DEEP_A, 32'h0);
		wb_xfer(1'b1, PCG_OFS_SLEEP_B, 32'h0000_1000);
		wb_xfer(1'b1, PCG_OFS_DEEP_B, 32'h0000_0003);
		@(posedge core_clk);
		sleep_mode <= 1'b1;
		tick(2);
		check(32'(active_mode), 32'(PCG_MODE_RUN));
		check(32'(unit_clk_en), en_of(32'h0, 32'h10));
		wb_xfer(1'b1, PCG_OFS_MODE_CTRL, 32'h1);
		tick(2);
		check(32'(active_mode), 32'(PCG_MODE_SLEEP));
		check(32'(unit_clk_en), en_of(32'h8, 32'h1000));
		@(posedge core_clk);
		deep_sleep_mode <= 1'b1;
		tick(2);
		check(32'(active_mode), 32'(PCG_MODE_DEEP));
		check(32'(unit_clk_en), en_of(32'h0, 32'h3));
		access(3'h0, 1'b0);
		@(posedge core_clk);
		sleep_mode <= 1'b0;
		deep_sleep_mode <= 1'b0;
		tick(2);
		check(32'(unit_clk_en), en_of(32'h0, 32'h10));
		// status is sticky and masked until enabled
		// earlier faults and gate changes have both latched by now
		rchk(PCG_OFS_IRQ_STATUS, 32'h3);
		wb_xfer(1'b1, PCG_OFS_IRQ_CLEAR, 32'h3);
		rchk(PCG_OFS_IRQ_STATUS, 32'h0);
		access(3'h6, 1'b0);
		tick(2);
		check(32'(irq), 32'h0);
		rchk(PCG_OFS_IRQ_STATUS, 32'h1);
		wb_xfer(1'b1, PCG_OFS_IRQ_ENABLE, 32'h1);
		tick(1);
		check(32'(irq), 32'h1);
		rchk(PCG_OFS_IRQ_ENABLE, 32'h1);
		wb_xfer(1'b1, PCG_OFS_IRQ_CLEAR, 32'h1);
		tick(2);
		check(32'(irq), 32'h0);
		rchk(PCG_OFS_IRQ_CLEAR, 32'h0);
		wb_xfer(1'b1, 12'h1fc, 32'hffff_ffff);
		rchk(12'h1fc, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire

// ==== dv/pcg_unit_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcg_unit_model (
	input wire logic rst_n,
	input wire logic [7:0] unit_clk,
	output logic [15:0] edge_cnt [8]
);
	// a unit only advances on edges of its own gated clock; a clipped pulse would miscount
	for (genvar i = 0; i < 8; i++) begin : g_unit
		always @(posedge unit_clk[i] or negedge rst_n) begin
			if (!rst_n) begin
				edge_cnt[i] <= 16'h0000;
			end else begin
				edge_cnt[i] <= edge_cnt[i] + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hdl/pcg_clock_gate.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcg_clock_gate (
	input wire logic clk,
	input wire logic enable,
	output logic gated_clk
);

	logic enable_latched;

	// latch is transparent while clk is low, so enable can only change
	// between pulses and no high phase is ever cut short
	always_latch begin
		if (!clk) begin
			enable_latched <= enable;
		end
	end

	assign gated_clk = clk & enable_latched;

endmodule
`default_nettype wire

// ==== hdl/pcg_top.sv ====
// What this block does
// - gate bit one: unit gets its clock and runs.
// - gate bit zero: unit clock stopped, unit disabled.
// - access to an unclocked unit is answered with a bus fault.
// - every gate bit is zero after reset.
// - three gate copies per group: run, sleep, deep sleep.
// - sleep and deep-sleep copies apply only with auto sleep gating set.
// - deep-sleep group a register at 0x120 holds watchdog gate, bit 3.
// - run group b holds timer c, b, a gates at bits 18, 17, 16.
// - run group b at 0x104 holds two-wire bus gate at bit 12.
// - run group b holds synchronous serial gate at bit 4.
// - run group b holds asynchronous serial b, a gates at bits 1, 0.
// - unused gate bits read zero and ignore writes.
// - positions for absent units behave as read-only zero.
// - sleep group a register at 0x110 holds watchdog gate, bit 3.
`timescale 1ns/1ps
`default_nettype none
module pcg_top
	import pcg_pkg::*;
#(
	parameter int unsigned NUM_UNITS = PCG_NUM_UNITS
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [PCG_ADDR_W-1:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [PCG_DATA_W-1:0] wb_dat_w,
	output logic [PCG_DATA_W-1:0] wb_dat_r,
	output logic wb_ack,
	input wire logic sleep_mode,
	input wire logic deep_sleep_mode,
	input wire logic per_access_valid,
	input wire logic [2:0] per_access_unit,
	output logic per_access_grant,
	output logic per_access_fault,
	output logic [NUM_UNITS-1:0] unit_clk,
	output logic [NUM_UNITS-1:0] unit_clk_en,
	output pcg_mode_t active_mode,
	output logic irq
);

	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
			input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] lanes;
		lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge_bytes = ((old_val & ~lanes) | (new_val & lanes)) & mask;
	endfunction

	// one bit per unit, taken from a pair of group copies
	function automatic logic [7:0] gather_units(input logic [31:0] grp_a, input logic [31:0] grp_b);
		logic [7:0] v;
		v = 8'h00;
		v[PCG_UNIT_WATCHDOG] = grp_a[PCG_BIT_WATCHDOG];
		v[PCG_UNIT_TIMER_A] = grp_b[PCG_BIT_TIMER_A];
		v[PCG_UNIT_TIMER_B] = grp_b[PCG_BIT_TIMER_B];
		v[PCG_UNIT_TIMER_C] = grp_b[PCG_BIT_TIMER_C];
		v[PCG_UNIT_TWO_WIRE] = grp_b[PCG_BIT_TWO_WIRE];
		v[PCG_UNIT_SYNC_SERIAL] = grp_b[PCG_BIT_SYNC_SERIAL];
		v[PCG_UNIT_ASYNC_A] = grp_b[PCG_BIT_ASYNC_A];
		v[PCG_UNIT_ASYNC_B] = grp_b[PCG_BIT_ASYNC_B];
		gather_units = v;
	endfunction

	// ***************************************************
	// bus decode
	// ***************************************************
	logic wb_ack_q;
	logic [31:0] wb_dat_q;
	logic bus_req;
	logic bus_wr;
	logic bus_rd;

	assign bus_req = wb_cyc && wb_stb && !wb_ack_q;
	assign bus_wr = bus_req && wb_we;
	assign bus_rd = bus_req && !wb_we;

	// one wait state: ack rises in the cycle after the request, falls next
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_q <= 1'b0;
		end else begin
			wb_ack_q <= bus_req;
		end
	end

	// ***************************************************
	// gate copies
	// ***************************************************
	logic [31:0] run_a_q;
	logic [31:0] run_b_q;
	logic [31:0] sleep_a_q;
	logic [31:0] sleep_b_q;
	logic [31:0] deep_a_q;
	logic [31:0] deep_b_q;
	logic [31:0] mode_ctrl_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_a_q <= PCG_RST_GATE;
			run_b_q <= PCG_RST_GATE;
		end else if (bus_wr && wb_adr == PCG_OFS_RUN_A) begin
			run_a_q <= merge_bytes(run_a_q, wb_dat_w, wb_sel, PCG_MASK_A);
		end else if (bus_wr && wb_adr == PCG_OFS_RUN_B) begin
			run_b_q <= merge_bytes(run_b_q, wb_dat_w, wb_sel, PCG_MASK_B);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_a_q <= PCG_RST_GATE;
			sleep_b_q <= PCG_RST_GATE;
		end else if (bus_wr && wb_adr == PCG_OFS_SLEEP_A) begin
			sleep_a_q <= merge_bytes(sleep_a_q, wb_dat_w, wb_sel, PCG_MASK_A);
		end else if (bus_wr && wb_adr == PCG_OFS_SLEEP_B) begin
			sleep_b_q <= merge_bytes(sleep_b_q, wb_dat_w, wb_sel, PCG_MASK_B);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			deep_a_q <= PCG_RST_GATE;
			deep_b_q <= PCG_RST_GATE;
		end else if (bus_wr && wb_adr == PCG_OFS_DEEP_A) begin
			deep_a_q <= merge_bytes(deep_a_q, wb_dat_w, wb_sel, PCG_MASK_A);
		end else if (bus_wr && wb_adr == PCG_OFS_DEEP_B) begin
			deep_b_q <= merge_bytes(deep_b_q, wb_dat_w, wb_sel, PCG_MASK_B);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ctrl_q <= PCG_RST_MODE;
		end else if (bus_wr && wb_adr == PCG_OFS_MODE_CTRL) begin
			mode_ctrl_q <= merge_bytes(mode_ctrl_q, wb_dat_w, wb_sel, PCG_MASK_MODE);
		end
	end

	// ***************************************************
	// mode selection and effective gates
	// ***************************************************
	logic auto_sleep_gating_select;
	pcg_mode_t mode_d;
	pcg_mode_t mode_q;
	logic [NUM_UNITS-1:0] unit_en_d;
	logic [NUM_UNITS-1:0] unit_en_q;

	assign auto_sleep_gating_select = mode_ctrl_q[PCG_BIT_AUTO_SLEEP];

	// without auto gating the run copy stays in force in every power state
	always_comb begin
		mode_d = PCG_MODE_RUN;
		if (auto_sleep_gating_select && deep_sleep_mode) begin
			mode_d = PCG_MODE_DEEP;
		end else if (auto_sleep_gating_select && sleep_mode) begin
			mode_d = PCG_MODE_SLEEP;
		end
	end

	always_comb begin
		case (mode_d)
			PCG_MODE_RUN: begin
				unit_en_d = gather_units(run_a_q, run_b_q);
			end
			PCG_MODE_SLEEP: begin
				unit_en_d = gather_units(sleep_a_q, sleep_b_q);
			end
			PCG_MODE_DEEP: begin
				unit_en_d = gather_units(deep_a_q, deep_b_q);
			end
			default: begin
				unit_en_d = gather_units(run_a_q, run_b_q);
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= PCG_MODE_RUN;
			unit_en_q <= '0;
		end else begin
			mode_q <= mode_d;
			unit_en_q <= unit_en_d;
		end
	end

	// ***************************************************
	// clock gate cells
	// ***************************************************
	for (genvar u = 0; u < NUM_UNITS; u++) begin : g_gate
		pcg_clock_gate u_gate (
			.clk(core_clk),
			.enable(unit_en_q[u]),
			.gated_clk(unit_clk[u])
		);
	end

	// ***************************************************
	// peripheral access check
	// ***************************************************
	// units rely on software enabling them first; any slip lands here
	logic grant_q;
	logic fault_q;
	logic fault_evt;

	assign fault_evt = per_access_valid && !unit_en_q[per_access_unit];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			grant_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			grant_q <= per_access_valid && unit_en_q[per_access_unit];
			fault_q <= fault_evt;
		end
	end

	// ***************************************************
	// interrupts
	// ***************************************************
	logic [PCG_IRQ_W-1:0] irq_status_q;
	logic [PCG_IRQ_W-1:0] irq_enable_q;
	logic [PCG_IRQ_W-1:0] irq_event;
	logic [PCG_IRQ_W-1:0] irq_clear;
	logic irq_q;

	always_comb begin
		irq_event = '0;
		irq_event[PCG_BIT_IRQ_FAULT] = fault_evt;
		irq_event[PCG_BIT_IRQ_CHANGE] = (unit_en_d != unit_en_q);
		irq_clear = '0;
		if (bus_wr && wb_adr == PCG_OFS_IRQ_CLEAR && wb_sel[0]) begin
			irq_clear = wb_dat_w[PCG_IRQ_W-1:0];
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_q <= PCG_RST_IRQ;
		end else begin
			irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_q <= PCG_RST_IRQ;
		end else if (bus_wr && wb_adr == PCG_OFS_IRQ_ENABLE && wb_sel[0]) begin
			irq_enable_q <= wb_dat_w[PCG_IRQ_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_enable_q);
		end
	end

	// ***************************************************
	// read back
	// ***************************************************
	// unmapped and write-only offsets read zero and still get ack
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_q <= 32'h0000_0000;
		end else if (bus_rd) begin
			case (wb_adr)
				PCG_OFS_RUN_A: wb_dat_q <= run_a_q;
				PCG_OFS_RUN_B: wb_dat_q <= run_b_q;
				PCG_OFS_SLEEP_A: wb_dat_q <= sleep_a_q;
				PCG_OFS_SLEEP_B: wb_dat_q <= sleep_b_q;
				PCG_OFS_DEEP_A: wb_dat_q <= deep_a_q;
				PCG_OFS_DEEP_B: wb_dat_q <= deep_b_q;
				PCG_OFS_MODE_CTRL: wb_dat_q <= mode_ctrl_q;
				PCG_OFS_IRQ_STATUS: wb_dat_q <= {{(32-PCG_IRQ_W){1'b0}}, irq_status_q};
				PCG_OFS_IRQ_ENABLE: wb_dat_q <= {{(32-PCG_IRQ_W){1'b0}}, irq_enable_q};
				default: wb_dat_q <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_dat_r = wb_dat_q;
	assign wb_ack = wb_ack_q;
	assign per_access_grant = grant_q;
	assign per_access_fault = fault_q;
	assign unit_clk_en = unit_en_q;
	assign active_mode = mode_q;
	assign irq = irq_q;

	// ***************************************************
	// checks
	// ***************************************************
	property p_fault_unclocked;
		@(posedge core_clk) disable iff (!rst_n)
		per_access_valid && !unit_en_q[per_access_unit] |=> per_access_fault && !per_access_grant;
	endproperty
	a_fault_unclocked: assert property (p_fault_unclocked) else $error("no fault on unclocked access");

	property p_grant_clocked;
		@(posedge core_clk) disable iff (!rst_n)
		per_access_valid && unit_en_q[per_access_unit] |=> per_access_grant && !per_access_fault;
	endproperty
	a_grant_clocked: assert property (p_grant_clocked) else $error("clocked access not granted");

	property p_run_copy_when_manual;
		@(posedge core_clk) disable iff (!rst_n)
		!auto_sleep_gating_select |=> unit_clk_en == gather_units($past(run_a_q), $past(run_b_q));
	endproperty
	a_run_copy_when_manual: assert property (p_run_copy_when_manual) else $error("sleep copy used without auto");

	property p_deep_copy;
		@(posedge core_clk) disable iff (!rst_n)
		auto_sleep_gating_select && deep_sleep_mode
			|=> active_mode == PCG_MODE_DEEP && unit_clk_en == gather_units($past(deep_a_q), $past(deep_b_q));
	endproperty
	a_deep_copy: assert property (p_deep_copy) else $error("deep sleep copy not applied");

	property p_all_off;
		@(posedge core_clk) disable iff (!rst_n)
		(run_a_q == 32'h0 && run_b_q == 32'h0 && !auto_sleep_gating_select)[*2] |-> unit_clk_en == '0;
	endproperty
	a_all_off: assert property (p_all_off) else $error("clock running with gate bit zero");

	property p_reserved_zero;
		@(posedge core_clk) disable iff (!rst_n)
		((run_b_q | sleep_b_q | deep_b_q) & ~PCG_MASK_B) == 32'h0
			&& ((run_a_q | sleep_a_q | deep_a_q) & ~PCG_MASK_A) == 32'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("unused gate bit set");

	property p_deep_watchdog_write;
		@(posedge core_clk) disable iff (!rst_n)
		bus_wr && wb_adr == PCG_OFS_DEEP_A && wb_sel[0]
			|=> deep_a_q[PCG_BIT_WATCHDOG] == $past(wb_dat_w[PCG_BIT_WATCHDOG]);
	endproperty
	a_deep_watchdog_write: assert property (p_deep_watchdog_write) else $error("deep watchdog bit not written");

	property p_run_b_write;
		@(posedge core_clk) disable iff (!rst_n)
		bus_wr && wb_adr == PCG_OFS_RUN_B && wb_sel == 4'hf |=> run_b_q == ($past(wb_dat_w) & PCG_MASK_B);
	endproperty
	a_run_b_write: assert property (p_run_b_write) else $error("run group b write wrong");

	property p_ack_single;
		@(posedge core_clk) disable iff (!rst_n)
		wb_cyc && wb_stb && !wb_ack |=> wb_ack ##1 !wb_ack;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack not a one-cycle answer");

	property p_irq_follows;
		@(posedge core_clk) disable iff (!rst_n)
		|(irq_status_q & irq_enable_q) |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

endmodule
`default_nettype wire

// ==== shared/pcg_pkg.sv ====
`default_nettype none
package pcg_pkg;

	// ***************************************************
	// sizes
	// ***************************************************
	localparam int unsigned PCG_NUM_UNITS = 8;
	localparam int unsigned PCG_ADDR_W = 12;
	localparam int unsigned PCG_DATA_W = 32;
	localparam int unsigned PCG_IRQ_W = 2;

	// ***************************************************
	// register byte offsets
	// ***************************************************
	localparam logic [11:0] PCG_OFS_RUN_A = 12'h100;
	localparam logic [11:0] PCG_OFS_RUN_B = 12'h104;
	localparam logic [11:0] PCG_OFS_SLEEP_A = 12'h110;
	localparam logic [11:0] PCG_OFS_SLEEP_B = 12'h114;
	localparam logic [11:0] PCG_OFS_DEEP_A = 12'h120;
	localparam logic [11:0] PCG_OFS_DEEP_B = 12'h124;
	localparam logic [11:0] PCG_OFS_MODE_CTRL = 12'h130;
	localparam logic [11:0] PCG_OFS_IRQ_STATUS = 12'h140;
	localparam logic [11:0] PCG_OFS_IRQ_CLEAR = 12'h144;
	localparam logic [11:0] PCG_OFS_IRQ_ENABLE = 12'h148;

	// ***************************************************
	// field positions
	// ***************************************************
	localparam int unsigned PCG_BIT_WATCHDOG = 3;
	localparam int unsigned PCG_BIT_TIMER_C = 18;
	localparam int unsigned PCG_BIT_TIMER_B = 17;
	localparam int unsigned PCG_BIT_TIMER_A = 16;
	localparam int unsigned PCG_BIT_TWO_WIRE = 12;
	localparam int unsigned PCG_BIT_SYNC_SERIAL = 4;
	localparam int unsigned PCG_BIT_ASYNC_B = 1;
	localparam int unsigned PCG_BIT_ASYNC_A = 0;
	localparam int unsigned PCG_BIT_AUTO_SLEEP = 0;
	localparam int unsigned PCG_BIT_IRQ_FAULT = 0;
	localparam int unsigned PCG_BIT_IRQ_CHANGE = 1;

	// writable bits of each group; everything else reads zero
	localparam logic [31:0] PCG_MASK_A = 32'h0000_0008;
	localparam logic [31:0] PCG_MASK_B = 32'h0007_1013;
	localparam logic [31:0] PCG_MASK_MODE = 32'h0000_0001;

	// ***************************************************
	// reset values
	// ***************************************************
	localparam logic [31:0] PCG_RST_GATE = 32'h0000_0000;
	localparam logic [31:0] PCG_RST_MODE = 32'h0000_0000;
	localparam logic [1:0] PCG_RST_IRQ = 2'h0;

	// ***************************************************
	// unit indices of the gated clock vector
	// ***************************************************
	localparam int unsigned PCG_UNIT_WATCHDOG = 0;
	localparam int unsigned PCG_UNIT_TIMER_A = 1;
	localparam int unsigned PCG_UNIT_TIMER_B = 2;
	localparam int unsigned PCG_UNIT_TIMER_C = 3;
	localparam int unsigned PCG_UNIT_TWO_WIRE = 4;
	localparam int unsigned PCG_UNIT_SYNC_SERIAL = 5;
	localparam int unsigned PCG_UNIT_ASYNC_A = 6;
	localparam int unsigned PCG_UNIT_ASYNC_B = 7;

	typedef enum logic [1:0] {
		PCG_MODE_RUN,
		PCG_MODE_SLEEP,
		PCG_MODE_DEEP
	} pcg_mode_t;

endpackage
`default_nettype wire
